// >>> logic/pointer_add_literal_ops.sv
// Executes the add-literal-to-pointer and add-pointer2-and-return instructions
// How it works
// - Add literal to selected pointer, one cycle
// - Variant adds literal to pointer 2 only
// - Variant then loads PC from stack, pops
// - Variant takes two cycles, second is nop
// - Select value three means add-and-return
// - Recognised only with extended set enabled
// - Sums kept as twelve-bit addresses
`timescale 1ns/1ps
module pointer_add_literal_ops (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration
    input wire logic extendedSetEnable,
    // Instruction in execute stage
    input wire logic instrValid,
    input wire logic [15:0] instr,
    // Core side pointer loads
    input wire logic [pointer_add_pkg::POINTER_COUNT-1:0] ptrLoadEn,
    input wire logic [pointer_add_pkg::ADDR_W-1:0] ptrLoadValue,
    // Return stack top
    input wire logic [pointer_add_pkg::PC_W-1:0] topOfReturnStack,
    // Pointer values
    output logic [pointer_add_pkg::ADDR_W-1:0] pointer0,
    output logic [pointer_add_pkg::ADDR_W-1:0] pointer1,
    output logic [pointer_add_pkg::ADDR_W-1:0] pointer2,
    // Return request and pipeline control
    output pointer_add_pkg::return_req_t returnReq,
    output logic nopCycle,
    output logic busy,
    output logic hit
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    pointer_add_pkg::decoded_t dec;          // Decoded fields
    logic opMatch;                           // Opcode byte matches

    typedef enum logic [0:0] {
        EXEC,
        RET_NOP
    } phase_t;
    phase_t phase_q;                         // Execution phase
    phase_t phase_d;                         // Next phase

    // Instruction field decode
    always_comb begin
        opMatch = instr[pointer_add_pkg::OPC_HI:pointer_add_pkg::OPC_LO]
                  == pointer_add_pkg::OPC_ADD_PTR;
        dec.sel = instr[pointer_add_pkg::SEL_HI:pointer_add_pkg::SEL_LO];
        dec.lit = instr[pointer_add_pkg::LIT_HI:pointer_add_pkg::LIT_LO];
        dec.addPtr = 1'b0;
        dec.addRet = 1'b0;
        if (instrValid && extendedSetEnable && opMatch && phase_q == EXEC) begin
            if (dec.sel == pointer_add_pkg::SEL_RETURN) begin
                dec.addRet = 1'b1;
            end else begin
                dec.addPtr = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pointer registers
    // ------------------------------------------------------------
    logic [pointer_add_pkg::ADDR_W-1:0] ptrVal [pointer_add_pkg::POINTER_COUNT]; // Values
    logic [pointer_add_pkg::POINTER_COUNT-1:0] addEn; // Per-pointer add strobe

    // Pick the pointer to add into; select three never reaches this loop
    always_comb begin
        addEn = '0;
        for (int i = 0; i < pointer_add_pkg::POINTER_COUNT; i++) begin
            if (dec.addPtr && dec.sel == 2'(i)) begin
                addEn[i] = 1'b1;
            end
        end
        if (dec.addRet) begin
            addEn[pointer_add_pkg::SEL_PTR2] = 1'b1;
        end
    end

    // One slot per pointer
    for (genvar i = 0; i < pointer_add_pkg::POINTER_COUNT; i++) begin : g_ptr
        pointer_slot u_slot (
            .clock(clock),
            .rst(rst),
            .addEn(addEn[i]),
            .lit(dec.lit),
            .loadEn(ptrLoadEn[i]),
            .loadValue(ptrLoadValue),
            .value(ptrVal[i])
        );
    end

    assign pointer0 = ptrVal[0];
    assign pointer1 = ptrVal[1];
    assign pointer2 = ptrVal[2];

    // ------------------------------------------------------------
    // Return sequencing
    // ------------------------------------------------------------
    // Next phase
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            EXEC: begin
                if (dec.addRet) begin
                    phase_d = RET_NOP;
                end
            end
            RET_NOP: begin
                phase_d = EXEC;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_q <= EXEC;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Return request, registered so data leaves a flop
    pointer_add_pkg::return_req_t ret_q;     // Held return request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ret_q <= '0;
        end else begin
            ret_q.pop <= dec.addRet;
            ret_q.pcLoad <= dec.addRet;
            if (dec.addRet) begin
                ret_q.pcValue <= topOfReturnStack;
            end
        end
    end

    // Request leaves the flop so the core sees a clean one-cycle pulse
    assign returnReq = ret_q;
    // Second cycle of a return; any instruction offered here is dropped
    assign nopCycle = (phase_q == RET_NOP);
    // Busy tells the core to stall fetch while the return target settles
    assign busy = dec.addRet;
    // Either instruction taken this cycle
    assign hit = dec.addPtr | dec.addRet;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence ret_issue_s;
        dec.addRet;
    endsequence

    sequence ret_finish_s;
        nopCycle && returnReq.pop && returnReq.pcLoad ##1 !nopCycle;
    endsequence

    add_select_a: assert property (@(posedge clock) disable iff (rst)
        dec.addPtr |=> ptrVal[$past(dec.sel)] ==
        $past(ptrVal[dec.sel]) + {6'h00, $past(dec.lit)})
        else $error("pointer add result wrong");

    add_ptr2_a: assert property (@(posedge clock) disable iff (rst)
        dec.addRet |=> pointer2 == $past(pointer2) + {6'h00, $past(dec.lit)})
        else $error("pointer 2 add result wrong");

    ret_load_a: assert property (@(posedge clock) disable iff (rst)
        dec.addRet |=> returnReq.pcValue == $past(topOfReturnStack))
        else $error("return target wrong");

    ret_two_a: assert property (@(posedge clock) disable iff (rst)
        ret_issue_s |=> ret_finish_s)
        else $error("return cycle sequence wrong");

    sel_three_a: assert property (@(posedge clock) disable iff (rst)
        dec.addRet |-> !addEn[0] && !addEn[1] && addEn[2])
        else $error("select three misdecoded");

    ext_gate_a: assert property (@(posedge clock) disable iff (rst)
        !extendedSetEnable |-> !hit)
        else $error("decoded with extension off");

    addr_wrap_a: assert property (@(posedge clock) disable iff (rst)
        addEn[0] |=>
        pointer0 == 12'({1'b0, $past(pointer0)} + {7'h00, $past(dec.lit)}))
        else $error("pointer sum not twelve bits");

    opc_match_a: assert property (@(posedge clock) disable iff (rst)
        hit |-> instr[15:8] == pointer_add_pkg::OPC_ADD_PTR && instrValid && extendedSetEnable)
        else $error("opcode not matched");

    no_pop_a: assert property (@(posedge clock) disable iff (rst)
        !$past(dec.addRet) |-> !returnReq.pop)
        else $error("spurious return stack pop");

    // A nop cycle decodes nothing
    nop_ignore_a: assert property (@(posedge clock) disable iff (rst)
        nopCycle |-> !hit && !busy)
        else $error("instruction taken in nop cycle");

    // A nop cycle leaves every pointer alone unless the core loads it
    nop_hold_a: assert property (@(posedge clock) disable iff (rst)
        nopCycle && ptrLoadEn == '0 |=>
        $stable(pointer0) && $stable(pointer1) && $stable(pointer2))
        else $error("pointer moved in nop cycle");

    // The return variant must not touch pointers 0 and 1
    ret_others_a: assert property (@(posedge clock) disable iff (rst)
        dec.addRet && ptrLoadEn == '0 |=> $stable(pointer0) && $stable(pointer1))
        else $error("return variant touched other pointer");

    // Pop and program counter load last exactly one cycle
    ret_pulse_a: assert property (@(posedge clock) disable iff (rst)
        returnReq.pop |=> !returnReq.pop && !returnReq.pcLoad)
        else $error("return request held too long");

endmodule

// >>> logic/pointer_add_pkg.sv
// Shared constants and carrier types for the pointer add-literal instruction block
package pointer_add_pkg;

    // ------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;              // Data space address width
    localparam int PC_W = 21;                // Program counter width
    localparam int LIT_W = 6;                // Literal width
    localparam logic [7:0] OPC_ADD_PTR = 8'hE8; // Opcode high byte
    localparam int OPC_HI = 15;              // Opcode field top bit
    localparam int OPC_LO = 8;               // Opcode field bottom bit
    localparam int SEL_HI = 7;               // Pointer select top bit
    localparam int SEL_LO = 6;               // Pointer select bottom bit
    localparam int LIT_HI = 5;               // Literal top bit
    localparam int LIT_LO = 0;               // Literal bottom bit
    localparam logic [1:0] SEL_RETURN = 2'h3; // Select value meaning add-and-return
    localparam logic [1:0] SEL_PTR2 = 2'h2;  // Pointer register 2 select

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000; // Pointer reset value
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000; // Program counter reset value
    localparam int POINTER_COUNT = 3;        // Number of pointer registers

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Decoded instruction fields
    typedef struct packed {
        logic addPtr;                        // Add literal to selected pointer
        logic addRet;                        // Add to pointer 2 and return
        logic [1:0] sel;                     // Target pointer
        logic [LIT_W-1:0] lit;               // Unsigned literal
    } decoded_t;

    // Return stack interface toward the core
    typedef struct packed {
        logic pop;                           // Pop return stack
        logic pcLoad;                        // Load program counter
        logic [PC_W-1:0] pcValue;            // New program counter
    } return_req_t;

endpackage

// >>> logic/pointer_slot.sv
// One file select pointer register with literal add
`timescale 1ns/1ps
module pointer_slot (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Update control
    input wire logic addEn,
    input wire logic [pointer_add_pkg::LIT_W-1:0] lit,
    // Direct load from core
    input wire logic loadEn,
    input wire logic [pointer_add_pkg::ADDR_W-1:0] loadValue,
    // Current value
    output logic [pointer_add_pkg::ADDR_W-1:0] value
);

    // ------------------------------------------------------------
    // Pointer storage
    // ------------------------------------------------------------
    logic [pointer_add_pkg::ADDR_W-1:0] ptr_q; // Held pointer
    logic [pointer_add_pkg::ADDR_W-1:0] ptr_d; // Next pointer

    // Sum wraps within the data space; add wins over a core load
    always_comb begin
        ptr_d = ptr_q;
        if (addEn) begin
            ptr_d = ptr_q + {{(pointer_add_pkg::ADDR_W-pointer_add_pkg::LIT_W){1'b0}}, lit};
        end else if (loadEn) begin
            ptr_d = loadValue;
        end
    end

    // Register update
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ptr_q <= pointer_add_pkg::PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    assign value = ptr_q;

endmodule

// >>> testbench/pointer_add_literal_ops_tb.sv
// Self-checking bench for the pointer add-literal instruction block
`timescale 1ns/1ps
module pointer_add_literal_ops_tb;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic clock = 1'b0; // Core clock
    logic rst = 1'b1; // Async reset
    logic extendedSetEnable = 1'b1; // Extension enabled
    logic instrValid = 1'b0; // Instruction present
    logic [15:0] instr = 16'h0000; // Instruction word
    logic [2:0] ptrLoadEn = 3'h0; // Pointer load strobes
    logic [11:0] ptrLoadValue = 12'h000; // Pointer load data
    logic [20:0] topOfReturnStack = 21'h000000; // Stack top
    logic [11:0] pointer0, pointer1, pointer2; // Pointer values
    pointer_add_pkg::return_req_t returnReq; // Return request
    logic nopCycle, busy, hit; // Pipeline flags
    int fail_count = 0; // Mismatches
    int n_compared = 0; // Comparisons
    int cycles = 0; // Timeout counter
    // ----------------------------------------------------------------
    // Clock, design and timeout
    // ----------------------------------------------------------------
    always #5 clock = ~clock;
    pointer_add_literal_ops u_dut (.clock(clock), .rst(rst),
        .extendedSetEnable(extendedSetEnable), .instrValid(instrValid), .instr(instr),
        .ptrLoadEn(ptrLoadEn), .ptrLoadValue(ptrLoadValue),
        .topOfReturnStack(topOfReturnStack), .pointer0(pointer0), .pointer1(pointer1),
        .pointer2(pointer2), .returnReq(returnReq), .nopCycle(nopCycle), .busy(busy),
        .hit(hit));
    // Cut a hang short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Compare one value and count it
    task automatic check(input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Pointer value by index
    function automatic logic [11:0] ptr_of(input int s);
        case (s)
            0: ptr_of = pointer0;
            1: ptr_of = pointer1;
            default: ptr_of = pointer2;
        endcase
    endfunction
    // Load one pointer through the core port
    task automatic load_ptr(input int sel, input logic [11:0] v);
        @(posedge clock);
        ptrLoadEn <= 3'h1 << sel;
        ptrLoadValue <= v;
        @(posedge clock);
        ptrLoadEn <= 3'h0;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Add the largest literal to each pointer, wrapping at the top
    task automatic test_add_each();
        for (int s = 0; s < 3; s++) begin
            load_ptr(s, 12'hFFE);
            instrValid <= 1'b1;
            instr <= {8'hE8, 2'(s), 6'h3F};
            #1 check(hit, 1'b1);
            check(busy, 1'b0);
            @(posedge clock);
            instrValid <= 1'b0;
            #1 check(ptr_of(s), 12'h03D);
            check(nopCycle, 1'b0);
        end
    endtask
    // Add-and-return, with an instruction offered in the nop cycle
    task automatic test_return();
        load_ptr(2, 12'h3FF);
        load_ptr(0, 12'h100);
        topOfReturnStack <= 21'h1ABCDE;
        instrValid <= 1'b1;
        instr <= 16'hE8E3;
        #1 check(hit, 1'b1);
        check(busy, 1'b1);
        @(posedge clock);
        instr <= 16'hE801;
        #1 check(pointer2, 12'h422);
        check(nopCycle, 1'b1);
        check(hit, 1'b0);
        check({returnReq.pop, returnReq.pcLoad}, 2'h3);
        check(returnReq.pcValue, 21'h1ABCDE);
        @(posedge clock);
        instrValid <= 1'b0;
        #1 check(pointer0, 12'h100);
        check({returnReq.pop, returnReq.pcLoad, nopCycle}, 3'h0);
        check(pointer1, 12'h03D);
    endtask
    // With the extension off nothing is recognised
    task automatic test_disabled();
        @(posedge clock);
        extendedSetEnable <= 1'b0;
        @(posedge clock);
        instrValid <= 1'b1;
        instr <= 16'hE8C5;
        #1 check({hit, busy}, 2'h0);
        @(posedge clock);
        instrValid <= 1'b0;
        #1 check(pointer2, 12'h422);
        check(nopCycle, 1'b0);
    endtask
    // Back-to-back adds, an add beside a load, and words that must not decode
    task automatic test_others();
        @(posedge clock);
        instrValid <= 1'b1;
        instr <= 16'hE842;
        @(posedge clock);
        instr <= 16'hE843;
        ptrLoadEn <= 3'h2;
        ptrLoadValue <= 12'h555;
        #1 check(pointer1, 12'h03F);
        check(hit, 1'b1);
        @(posedge clock);
        ptrLoadEn <= 3'h0;
        instr <= 16'hE9C5;
        #1 check(pointer1, 12'h042);
        check(hit, 1'b0);
        @(posedge clock);
        instrValid <= 1'b0;
        instr <= 16'hE805;
        #1 check(hit, 1'b0);
        @(posedge clock);
        #1 check(pointer0, 12'h100);
        check(pointer2, 12'h422);
        check(nopCycle, 1'b0);
    endtask
    // Reset in the nop cycle of a return, then a return right after release
    task automatic test_reset_mid();
        @(posedge clock);
        extendedSetEnable <= 1'b1;
        instrValid <= 1'b1;
        instr <= 16'hE8C1;
        @(posedge clock);
        instrValid <= 1'b0;
        rst <= 1'b1;
        #1 check(pointer2, 12'h000);
        check({returnReq.pop, returnReq.pcLoad, nopCycle}, 3'h0);
        check(returnReq.pcValue, 21'h000000);
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        instrValid <= 1'b1;
        @(posedge clock);
        instrValid <= 1'b0;
        #1 check(pointer2, 12'h001);
        check({returnReq.pop, returnReq.pcLoad, nopCycle}, 3'h7);
        check(returnReq.pcValue, 21'h1ABCDE);
        @(posedge clock);
        #1 check(nopCycle, 1'b0);
    endtask
    // Print counts and verdict, end the run
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1 check(pointer2, 12'h000);
        test_add_each();
        test_return();
        test_others();
        test_disabled();
        test_reset_mid();
        give_verdict();
    end
endmodule
